// ==== design/tpt_pkg.sv ====
// shared constants of the three channel pulse timer core
// assumes a 16-bit register bus, byte address with bit 0 zero, be[1] = bits 15:8
package tpt_pkg;
    localparam int          NUM_CH     = 3;
    localparam int          NUM_TGR    = 8;
    localparam int          ADDR_W     = 7;
    localparam int          DATA_W     = 16;

    // byte address = {channel, register}; channel 3 slot holds the common word
    localparam logic [6:0]  OFF_COMMON = 7'h30;
    localparam logic [3:0]  REG_CTRL   = 4'h0;
    localparam logic [3:0]  REG_IO     = 4'h2;
    localparam logic [3:0]  REG_STAT   = 4'h4;
    localparam logic [3:0]  REG_CNT    = 4'h6;
    localparam logic [3:0]  REG_GENERAL_REG_A   = 4'h8;
    localparam logic [3:0]  REG_GENERAL_REG_B   = 4'ha;
    localparam logic [3:0]  REG_GENERAL_REG_C   = 4'hc;
    localparam logic [3:0]  REG_GENERAL_REG_D   = 4'he;

    localparam logic [15:0] CNT_RST    = 16'h0000;
    localparam logic [15:0] CNT_MAX    = 16'hffff;
    localparam logic [15:0] TGR_RST    = 16'hffff;
    localparam logic [2:0]  RUN_RST    = 3'h0;
    localparam logic [2:0]  SYNC_RST   = 3'h0;
    localparam logic [7:0]  CFG_RST    = 8'h00;
    localparam logic [4:0]  FLG_RST    = 5'h00;

    // counter control byte
    localparam int          CLR_HI     = 1;
    localparam int          CLR_LO     = 0;
    localparam int          CLK_EXT    = 2;
    localparam logic [1:0]  CLR_NONE   = 2'h0;
    localparam logic [1:0]  CLR_A      = 2'h1;
    localparam logic [1:0]  CLR_B      = 2'h2;
    localparam logic [1:0]  CLR_SYNC   = 2'h3;

    // operating mode byte
    localparam int          MODE_PHASE = 0;
    localparam int          MODE_BUFA  = 1;
    localparam int          MODE_BUFB  = 2;

    // pin io nibble: A and C in bits 7:4, B and D in bits 3:0
    localparam int          IO_CAPT    = 3;
    localparam int          IO_INIT    = 2;
    localparam int          IO_ACT_HI  = 1;
    localparam int          IO_ACT_LO  = 0;
    localparam int          EDGE_RISE  = 0;
    localparam int          EDGE_FALL  = 1;
    localparam logic [1:0]  ACT_NONE   = 2'h0;
    localparam logic [1:0]  ACT_LOW    = 2'h1;
    localparam logic [1:0]  ACT_HIGH   = 2'h2;
    localparam logic [1:0]  ACT_TOGGLE = 2'h3;

    // status byte, bits 3:0 match flags A..D
    localparam int          STAT_OVF   = 4;
    localparam int          CH_BITS    = 3;
endpackage

// ==== design/tpt_bus_if.sv ====
// register bus between the bus master end and the timer core
// assumes both ends run on the same clock; no clocking here
`timescale 1ns/10ps
`default_nettype none
interface tpt_bus_if;
    logic [6:0]  addr;
    logic [15:0] wdata;
    logic [1:0]  be;
    logic        wr;
    logic        rd;
    logic [15:0] rdata;

    modport dev  (input addr, input wdata, input be, input wr, input rd, output rdata);
    modport host (output addr, output wdata, output be, output wr, output rd, input rdata);
endinterface
`default_nettype wire

// ==== design/tpt_host.sv ====
// bus master end: turns plain commands into bus cycles
// assumes the core answers a read in the cycle after the strobe
`timescale 1ns/10ps
`default_nettype none
module tpt_host (
    input  wire logic        clk,
    input  wire logic        rst,
    tpt_bus_if.host          bus,
    input  wire logic [6:0]  cmdAddr,
    input  wire logic [15:0] cmdWdata,
    input  wire logic [1:0]  cmdByteEn,
    input  wire logic        cmdWr,
    input  wire logic        cmdRd,
    output logic [15:0]      cmdRdata,
    output logic             cmdRdValid,
    output logic             cmdRefused
);
    function automatic logic lone(input logic [2:0] x);
        return (x != 3'h0) && ((x & (x - 3'h1)) == 3'h0);
    endfunction

    logic [2:0]  shadowRun;
    logic        rdPend;
    logic        isCom;
    logic        isWide;
    logic        busy;
    logic [2:0]  syncBits;
    logic [15:0] wd;

    always_comb begin
        isCom    = cmdAddr == tpt_pkg::OFF_COMMON;
        isWide   = ~cmdAddr[6] && cmdAddr[5:4] != 2'h3 && cmdAddr[3:0] >= tpt_pkg::REG_CNT;
        // mode and clock changes only on a stopped channel
        busy     = ~cmdAddr[6] && cmdAddr[5:4] != 2'h3 && cmdAddr[3:0] == tpt_pkg::REG_CTRL
                   && shadowRun[cmdAddr[5:4]]; // R10
        syncBits = cmdWdata[2:0];
        if (lone(syncBits)) begin
            syncBits = 3'h0; // R15
        end
        wd = cmdWdata;
        if (isCom) begin
            wd = {5'h00, cmdWdata[10:8], 5'h00, syncBits}; // R9
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            bus.addr   <= 7'h00;
            bus.wdata  <= 16'h0000;
            bus.be     <= 2'h0;
            bus.wr     <= 1'b0;
            bus.rd     <= 1'b0;
            cmdRefused <= 1'b0;
        end else begin
            bus.addr   <= cmdAddr;
            bus.wdata  <= wd;
            bus.be     <= isWide ? 2'h3 : cmdByteEn; // R4
            bus.wr     <= cmdWr & ~busy;
            bus.rd     <= cmdRd;
            cmdRefused <= cmdWr & busy;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            shadowRun <= tpt_pkg::RUN_RST;
        end else if (cmdWr && isCom && cmdByteEn[1]) begin
            shadowRun <= wd[10:8];
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rdPend     <= 1'b0;
            cmdRdValid <= 1'b0;
            cmdRdata   <= 16'h0000;
        end else begin
            rdPend     <= bus.rd;
            cmdRdValid <= rdPend;
            if (rdPend) begin
                cmdRdata <= bus.rdata;
            end
        end
    end
endmodule
`default_nettype wire

// ==== design/tpt_device.sv ====
// timer core: three counters, eight compare/capture registers, run and lockstep control
// assumes pins and event inputs are asynchronous; bus master obeys the host end's rules
//
// The register offsets and strobed register access were decided locally.
`timescale 1ns/10ps
`default_nettype none
// What this block does
// R1: three independent 16-bit counters, channels 0-2
// R2: counters reset to zero
// R3: channels 1,2 count down only in phase mode
// R4: master uses only 16-bit access for counters, registers
// R5: eight general registers, compare or capture each
// R6: general registers reset to all ones
// R7: channel 0 C buffers A, D buffers B
// R8: run register bits 2-0 start channels, reset zero
// R9: run/lockstep bits 7-3 read zero, written zero
// R10: stop counter before changing mode or clock
// R11: stopping keeps the compare pin level
// R12: io write while stopped drives initial level
// R13: lockstep select register bits 2-0, reset zero
// R14: counter write loads all lockstep counters together
// R15: lockstep needs at least two channels selected
// R16: lockstep clear needs clear source set to sync
// R17: byte registers take byte or paired word access
// R18: up count, free running or external events
// R19: overflow flag on wrap, cleared by read-then-zero
// R20: match flag on compare equality or capture
// R21: step once per count edge while running
module tpt_device (
    input  wire logic       clk,
    input  wire logic       rst,
    tpt_bus_if.dev          bus,
    input  wire logic [2:0] eventIn,
    input  wire logic [1:0] phaseAIn,
    input  wire logic [1:0] phaseBIn,
    input  wire logic [7:0] pinIn,
    output logic [7:0]      pinOut,
    output logic [7:0]      pinOe
);
    function automatic logic [1:0] chanOf(input int i);
        return (i < 4) ? 2'h0 : ((i < 6) ? 2'h1 : 2'h2);
    endfunction

    function automatic int baseOf(input logic [1:0] c);
        return (c == 2'h0) ? 0 : ((c == 2'h1) ? 4 : 6);
    endfunction

    function automatic logic [3:0] nib(input logic [7:0] b, input int l);
        return (l % 2 == 0) ? b[7:4] : b[3:0];
    endfunction

    logic [15:0] cnt [3];
    logic [15:0] compare_capture_value [8];
    logic [7:0]  ctrl [3];
    logic [7:0]  mode [3];
    logic [7:0]  io [6];
    logic [4:0]  flg [3];
    logic [4:0]  seen [3];
    logic [2:0]  run;
    logic [2:0]  sync;
    logic [14:0] sA;
    logic [14:0] sB;
    logic [14:0] sC;

    logic [1:0]  ach;
    logic [3:0]  areg;
    logic        chOk;
    logic        isCom;
    logic        full;
    logic [2:0]  step;
    logic [2:0]  up;
    logic [2:0]  ownClr;
    logic [2:0]  clr;
    logic [2:0]  load;
    logic [2:0]  ovf;
    logic [7:0]  match;
    logic [7:0]  capt;
    logic [7:0]  ev;
    logic [7:0]  own;
    logic [7:0]  wrTgr;
    logic [7:0]  ioLoad;
    logic [3:0]  ioNew [8];
    logic [3:0]  ioNib [8];
    logic [4:0]  flgSet [3];
    logic [15:0] rdMux;

    // pins enter through two flops; sC only keeps the previous settled value
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sA <= 15'h0000;
            sB <= 15'h0000;
            sC <= 15'h0000;
        end else begin
            sA <= {pinIn, phaseBIn, phaseAIn, eventIn};
            sB <= sA;
            sC <= sB;
        end
    end

    always_comb begin
        ach   = bus.addr[5:4];
        areg  = bus.addr[3:0];
        chOk  = ~bus.addr[6] && ach != 2'h3;
        isCom = bus.addr == tpt_pkg::OFF_COMMON;
        full  = &bus.be; // R4
        for (int c = 0; c < 3; c++) begin
            up[c]   = 1'b1; // R18
            step[c] = run[c] & (ctrl[c][tpt_pkg::CLK_EXT] ? (sB[c] & ~sC[c]) : 1'b1); // R21
            if (c != 0 && mode[c][tpt_pkg::MODE_PHASE]) begin
                step[c] = run[c] & ((sB[2+c] ^ sC[2+c]) | (sB[4+c] ^ sC[4+c])); // R3
                up[c]   = sB[2+c] ^ sC[4+c];
            end
            load[c] = bus.wr && chOk && areg == tpt_pkg::REG_CNT && full
                      && (ach == 2'(c) || (sync[c] && sync[ach])); // R14
        end
        for (int i = 0; i < 8; i++) begin
            ioNib[i]  = nib(io[2*chanOf(i) + (i - baseOf(chanOf(i)))/2], i - baseOf(chanOf(i)));
            own[i]    = ~((i == 2 && mode[0][tpt_pkg::MODE_BUFA]) || (i == 3 && mode[0][tpt_pkg::MODE_BUFB])); // R7
            capt[i]   = own[i] && ioNib[i][tpt_pkg::IO_CAPT]
                        && ((ioNib[i][tpt_pkg::EDGE_RISE] && sB[7+i] && ~sC[7+i])
                        || (ioNib[i][tpt_pkg::EDGE_FALL] && ~sB[7+i] && sC[7+i]));
            match[i]  = own[i] && ~ioNib[i][tpt_pkg::IO_CAPT]
                        && step[chanOf(i)] && cnt[chanOf(i)] == compare_capture_value[i];
            ev[i]     = capt[i] | match[i];
            wrTgr[i]  = bus.wr && chOk && full && ach == chanOf(i)
                        && areg == tpt_pkg::REG_GENERAL_REG_A + 4'(2 * (i - baseOf(chanOf(i))));
            ioLoad[i] = bus.wr && chOk && areg == tpt_pkg::REG_IO && ach == chanOf(i)
                        && (((i - baseOf(chanOf(i))) < 2) ? bus.be[1] : (bus.be[0] && i < 4)); // R17
            ioNew[i]  = nib(((i - baseOf(chanOf(i))) < 2) ? bus.wdata[15:8] : bus.wdata[7:0], i - baseOf(chanOf(i)));
        end
        for (int c = 0; c < 3; c++) begin
            ownClr[c] = (ctrl[c][tpt_pkg::CLR_HI:tpt_pkg::CLR_LO] == tpt_pkg::CLR_A && ev[baseOf(2'(c))])
                        || (ctrl[c][tpt_pkg::CLR_HI:tpt_pkg::CLR_LO] == tpt_pkg::CLR_B && ev[baseOf(2'(c)) + 1]);
        end
        for (int c = 0; c < 3; c++) begin
            clr[c] = ownClr[c] || (ctrl[c][tpt_pkg::CLR_HI:tpt_pkg::CLR_LO] == tpt_pkg::CLR_SYNC
                     && sync[c] && |(ownClr & sync)); // R16
            ovf[c] = step[c] && up[c] && cnt[c] == tpt_pkg::CNT_MAX && ~clr[c] && ~load[c];
        end
        flgSet[0] = {ovf[0], ev[3:0]}; // R20
        flgSet[1] = {ovf[1], 2'h0, ev[5:4]};
        flgSet[2] = {ovf[2], 2'h0, ev[7:6]};
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            for (int c = 0; c < 3; c++) begin
                cnt[c] <= tpt_pkg::CNT_RST; // R2
            end
        end else begin
            for (int c = 0; c < 3; c++) begin
                if (load[c]) begin
                    cnt[c] <= bus.wdata; // R14
                end else if (clr[c]) begin
                    cnt[c] <= tpt_pkg::CNT_RST;
                end else if (step[c]) begin
                    cnt[c] <= up[c] ? cnt[c] + 16'h0001 : cnt[c] - 16'h0001; // R1
                end
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < 8; i++) begin
                compare_capture_value[i] <= tpt_pkg::TGR_RST; // R6
            end
        end else begin
            for (int i = 0; i < 8; i++) begin
                if (wrTgr[i]) begin
                    compare_capture_value[i] <= bus.wdata; // R5
                end else if (capt[i]) begin
                    compare_capture_value[i] <= cnt[chanOf(i)];
                end
            end
            // buffer moves: compare pulls from the buffer, capture pushes the old value into it
            if (!wrTgr[0] && match[0] && mode[0][tpt_pkg::MODE_BUFA]) begin
                compare_capture_value[0] <= compare_capture_value[2]; // R7
            end
            if (!wrTgr[1] && match[1] && mode[0][tpt_pkg::MODE_BUFB]) begin
                compare_capture_value[1] <= compare_capture_value[3]; // R7
            end
            if (!wrTgr[2] && capt[0] && mode[0][tpt_pkg::MODE_BUFA]) begin
                compare_capture_value[2] <= compare_capture_value[0];
            end
            if (!wrTgr[3] && capt[1] && mode[0][tpt_pkg::MODE_BUFB]) begin
                compare_capture_value[3] <= compare_capture_value[1];
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            run  <= tpt_pkg::RUN_RST;
            sync <= tpt_pkg::SYNC_RST;
            for (int c = 0; c < 3; c++) begin
                ctrl[c] <= tpt_pkg::CFG_RST;
                mode[c] <= tpt_pkg::CFG_RST;
            end
            for (int b = 0; b < 6; b++) begin
                io[b] <= tpt_pkg::CFG_RST;
            end
        end else if (bus.wr) begin
            if (isCom && bus.be[1]) begin
                run <= bus.wdata[8 +: tpt_pkg::CH_BITS]; // R8
            end
            if (isCom && bus.be[0]) begin
                sync <= bus.wdata[0 +: tpt_pkg::CH_BITS]; // R13
            end
            if (chOk && areg == tpt_pkg::REG_CTRL && bus.be[1]) begin
                ctrl[ach] <= bus.wdata[15:8]; // R17
            end
            if (chOk && areg == tpt_pkg::REG_CTRL && bus.be[0]) begin
                mode[ach] <= bus.wdata[7:0];
            end
            if (chOk && areg == tpt_pkg::REG_IO && bus.be[1]) begin
                io[{ach, 1'b0}] <= bus.wdata[15:8];
            end
            if (chOk && areg == tpt_pkg::REG_IO && bus.be[0] && ach == 2'h0) begin
                io[1] <= bus.wdata[7:0];
            end
        end
    end

    // a stopped counter produces no match, so the pin simply holds
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pinOut <= 8'h00;
            pinOe  <= 8'h00;
        end else begin
            for (int i = 0; i < 8; i++) begin
                pinOe[i] <= ~ioNib[i][tpt_pkg::IO_CAPT];
                if (ioLoad[i] && !run[chanOf(i)]) begin
                    pinOut[i] <= ioNew[i][tpt_pkg::IO_INIT]; // R12
                end else if (match[i]) begin // R11
                    unique case (ioNib[i][tpt_pkg::IO_ACT_HI:tpt_pkg::IO_ACT_LO])
                        tpt_pkg::ACT_NONE:   pinOut[i] <= pinOut[i];
                        tpt_pkg::ACT_LOW:    pinOut[i] <= 1'b0;
                        tpt_pkg::ACT_HIGH:   pinOut[i] <= 1'b1;
                        tpt_pkg::ACT_TOGGLE: pinOut[i] <= ~pinOut[i];
                    endcase
                end
            end
        end
    end

    // set beats clear; clearing needs a prior read that saw the flag at one
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            for (int c = 0; c < 3; c++) begin
                flg[c]  <= tpt_pkg::FLG_RST;
                seen[c] <= tpt_pkg::FLG_RST;
            end
        end else begin
            for (int c = 0; c < 3; c++) begin
                if (bus.wr && chOk && ach == 2'(c) && areg == tpt_pkg::REG_STAT && bus.be[1]) begin
                    flg[c]  <= (flg[c] & ~(seen[c] & ~bus.wdata[12:8])) | flgSet[c]; // R19
                    seen[c] <= seen[c] & bus.wdata[12:8];
                end else begin
                    flg[c] <= flg[c] | flgSet[c]; // R20
                    if (bus.rd && chOk && ach == 2'(c) && areg == tpt_pkg::REG_STAT) begin
                        seen[c] <= seen[c] | flg[c];
                    end
                end
            end
        end
    end

    always_comb begin
        rdMux = 16'h0000;
        if (isCom) begin
            rdMux = {5'h00, run, 5'h00, sync}; // R9
        end else if (chOk) begin
            unique case (areg)
                tpt_pkg::REG_CTRL: rdMux = {ctrl[ach], mode[ach]};
                tpt_pkg::REG_IO:   rdMux = {io[{ach, 1'b0}], io[{ach, 1'b1}]};
                tpt_pkg::REG_STAT: rdMux = {3'h0, flg[ach], 8'h00};
                tpt_pkg::REG_CNT:  rdMux = cnt[ach];
                tpt_pkg::REG_GENERAL_REG_A: rdMux = compare_capture_value[baseOf(ach)];
                tpt_pkg::REG_GENERAL_REG_B: rdMux = compare_capture_value[baseOf(ach) + 1];
                tpt_pkg::REG_GENERAL_REG_C: rdMux = (ach == 2'h0) ? compare_capture_value[2] : 16'h0000;
                tpt_pkg::REG_GENERAL_REG_D: rdMux = (ach == 2'h0) ? compare_capture_value[3] : 16'h0000;
                default:           rdMux = 16'h0000;
            endcase
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            bus.rdata <= 16'h0000;
        end else if (bus.rd) begin
            bus.rdata <= rdMux;
        end
    end
endmodule
`default_nettype wire

// ==== tb/tpt_bus_assertions.sv ====
// bus checks for the timer register bus between host end and core
// assumes one clock domain; inputs are the interface signals themselves
`timescale 1ns/10ps
`default_nettype none
module tpt_bus_assertions (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic [6:0]  addr,
    input  wire logic [15:0] wdata,
    input  wire logic [1:0]  be,
    input  wire logic        wr,
    input  wire logic        rd,
    input  wire logic [15:0] rdata
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    wire logic isCom = (addr == tpt_pkg::OFF_COMMON);
    wire logic isChan = (addr < tpt_pkg::OFF_COMMON);

    strobe_excl_a: assert property (!(wr && rd))
        else $error("write and read strobes together");
    word_whole_a: assert property (wr && isChan && addr[3:0] >= 4'h6 |-> be == 2'b11)
        else $error("partial write to a word register");
    com_wmask_a: assert property (wr && isCom |-> wdata[15:11] == 5'h00 && wdata[7:3] == 5'h00)
        else $error("reserved run or lockstep bits written as one");
    lone_sync_a: assert property (wr && isCom && be[0] |-> $countones(wdata[2:0]) != 1)
        else $error("single lockstep channel written");
    com_rzero_a: assert property (rd && isCom |=> rdata[15:11] == 5'h00 && rdata[7:3] == 5'h00)
        else $error("reserved run or lockstep bits read as one");
    run_back_a: assert property (wr && isCom && be == 2'b11 ##1 !wr ##1 rd && isCom |=> rdata == $past(wdata, 3))
        else $error("run and lockstep read back differ");
    cd_absent_a: assert property (rd && (addr[6:4] == 3'h1 || addr[6:4] == 3'h2) && addr[3:2] == 2'b11
        |=> rdata == 16'h0000)
        else $error("absent register reads nonzero");
    stat_low_a: assert property (rd && isChan && addr[3:0] == 4'h4 |=> rdata[7:0] == 8'h00 && rdata[15:13] == 3'h0)
        else $error("status reserved bits nonzero");
    unmapped_a: assert property (rd && addr > tpt_pkg::OFF_COMMON |=> rdata == 16'h0000)
        else $error("unmapped address reads nonzero");
    rd_hold_a: assert property (!rd |=> $stable(rdata))
        else $error("read data moved without a read");
endmodule
`default_nettype wire

// ==== tb/tpt_tb.sv ====
// testbench: host end and timer core joined by the bus, driven by commands
// assumes the hand-over latencies of both ends; one 100 MHz clock
`timescale 1ns/10ps
`default_nettype none
module tpt_tb;
    logic        clk;
    logic        rst;
    logic [6:0]  cmdAddr;
    logic [15:0] cmdWdata;
    logic [1:0]  cmdByteEn;
    logic        cmdWr;
    logic        cmdRd;
    logic [15:0] cmdRdata;
    logic        cmdRdValid;
    logic        cmdRefused;
    logic [2:0]  eventIn;
    logic [1:0]  phaseAIn;
    logic [1:0]  phaseBIn;
    logic [7:0]  pinIn;
    logic [7:0]  pinOut;
    logic [7:0]  pinOe;
    logic        refusedSeen;
    logic [15:0] v;
    int          errTotal;
    int          checkCount;
    int          tgrM [3][4];

    tpt_bus_if bus ();
    tpt_host u_tpt_host (.clk(clk), .rst(rst), .bus(bus), .cmdAddr(cmdAddr), .cmdWdata(cmdWdata),
        .cmdByteEn(cmdByteEn), .cmdWr(cmdWr), .cmdRd(cmdRd), .cmdRdata(cmdRdata), .cmdRdValid(cmdRdValid),
        .cmdRefused(cmdRefused));
    tpt_device u_tpt_device (.clk(clk), .rst(rst), .bus(bus), .eventIn(eventIn), .phaseAIn(phaseAIn),
        .phaseBIn(phaseBIn), .pinIn(pinIn), .pinOut(pinOut), .pinOe(pinOe));
    tpt_bus_assertions u_tpt_bus_assertions (.clk(clk), .rst(rst), .addr(bus.addr), .wdata(bus.wdata),
        .be(bus.be), .wr(bus.wr), .rd(bus.rd), .rdata(bus.rdata));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    always @(posedge clk) begin
        if (rst) begin
            refusedSeen <= 1'b0;
        end else if (cmdRefused === 1'b1) begin
            refusedSeen <= 1'b1;
        end
    end

    function automatic logic [6:0] ad(input int c, input logic [3:0] r);
        ad = {c[2:0], r};
    endfunction

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checkCount++;
        if (seen !== exp) begin
            errTotal++;
            $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // lowers the strobe a cycle later, so calls never collide in one step
    task automatic wr(input logic [6:0] a, input logic [15:0] d, input logic [1:0] b);
        cmdAddr <= a;
        cmdWdata <= d;
        cmdByteEn <= b;
        cmdWr <= 1'b1;
        @(posedge clk);
        cmdWr <= 1'b0;
        @(posedge clk);
    endtask

    task automatic rdchk(input logic [6:0] a, input logic [15:0] exp);
        int n;
        cmdAddr <= a;
        cmdRd <= 1'b1;
        @(posedge clk);
        cmdRd <= 1'b0;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (cmdRdValid !== 1'b1 && n < 8);
        if (n >= 8) begin
            errTotal++;
        end
        check(cmdRdata, exp);
    endtask

    task automatic chk_tgr();
        for (int c = 0; c < 3; c++) begin
            for (int r = 0; r < 4; r++) begin
                rdchk(ad(c, tpt_pkg::REG_GENERAL_REG_A + 4'(2 * r)), 16'(tgrM[c][r]));
            end
        end
    endtask

    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", checkCount, errTotal);
        if (errTotal == 0 && checkCount > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge clk);
        errTotal++;
        end_of_test();
    end

    initial begin
        rst = 1'b1;
        {cmdAddr, cmdWdata, cmdByteEn, cmdWr, cmdRd} = '0;
        {eventIn, phaseAIn, phaseBIn, pinIn} = '0;
        errTotal = 0;
        checkCount = 0;
        v = 16'($urandom(32'h5428));
        for (int c = 0; c < 3; c++) begin
            for (int r = 0; r < 4; r++) begin
                tgrM[c][r] = (c == 0 || r < 2) ? int'(tpt_pkg::TGR_RST) : 0;
            end
        end
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        for (int c = 0; c < 3; c++) begin
            rdchk(ad(c, tpt_pkg::REG_CNT), tpt_pkg::CNT_RST);
        end
        rdchk(tpt_pkg::OFF_COMMON, 16'h0000);
        rdchk(7'h40, 16'h0000);
        chk_tgr();
        // byte enable 01 on word registers: host widens it to a whole word
        for (int c = 0; c < 3; c++) begin
            for (int r = 0; r < 4; r++) begin
                v = 16'($urandom);
                if (c == 0 || r < 2) begin
                    tgrM[c][r] = v;
                end
                wr(ad(c, tpt_pkg::REG_GENERAL_REG_A + 4'(2 * r)), v, 2'b01);
            end
        end
        chk_tgr();
        wr(tpt_pkg::OFF_COMMON, 16'hf8ff, 2'b11);
        rdchk(tpt_pkg::OFF_COMMON, 16'h0007);
        wr(tpt_pkg::OFF_COMMON, 16'h0002, 2'b01);
        rdchk(tpt_pkg::OFF_COMMON, 16'h0000);
        wr(tpt_pkg::OFF_COMMON, 16'h0003, 2'b01);
        wr(ad(1, tpt_pkg::REG_CNT), 16'h1234, 2'b11);
        rdchk(ad(0, tpt_pkg::REG_CNT), 16'h1234);
        rdchk(ad(2, tpt_pkg::REG_CNT), 16'h0000);
        wr(tpt_pkg::OFF_COMMON, 16'h0000, 2'b01);
        // ch0 pin A: compare, start high, toggle on match
        wr(ad(0, tpt_pkg::REG_IO), 16'h7000, 2'b10);
        repeat (3) @(posedge clk);
        check({14'h0, pinOe[0], pinOut[0]}, 16'h0003);
        wr(ad(0, tpt_pkg::REG_GENERAL_REG_A), 16'hfff8, 2'b11);
        wr(ad(0, tpt_pkg::REG_CNT), 16'hfff0, 2'b11);
        wr(tpt_pkg::OFF_COMMON, 16'h0100, 2'b10);
        repeat (40) @(posedge clk);
        wr(tpt_pkg::OFF_COMMON, 16'h0000, 2'b10);
        repeat (10) @(posedge clk);
        check({15'h0, pinOut[0]}, 16'h0000);
        // 42 steps from fff0: compared values fff0..0019, ends at 001a
        rdchk(ad(0, tpt_pkg::REG_CNT), 16'h001a);
        check({15'h0, cmdRdata < 16'h0040}, 16'h0001);
        v = 16'h1100;
        for (int r = 1; r < 4; r++) begin
            if (tgrM[0][r] >= 32'h0000fff0 || tgrM[0][r] <= 32'h00000019) begin
                v = v | (16'h0100 << r);
            end
        end
        rdchk(ad(0, tpt_pkg::REG_STAT), v);
        check(cmdRdata & 16'h1100, 16'h1100);
        wr(ad(0, tpt_pkg::REG_STAT), 16'h0000, 2'b10);
        rdchk(ad(0, tpt_pkg::REG_STAT), 16'h0000);
        // ch2 counts external events only
        wr(ad(2, tpt_pkg::REG_CTRL), 16'h0400, 2'b10);
        wr(tpt_pkg::OFF_COMMON, 16'h0400, 2'b10);
        wr(ad(2, tpt_pkg::REG_CTRL), 16'h0000, 2'b10);
        @(posedge clk);
        check({15'h0, refusedSeen}, 16'h0001);
        for (int k = 0; k < 5; k++) begin
            eventIn <= 3'b100;
            repeat (3) @(posedge clk);
            eventIn <= 3'b000;
            repeat (3) @(posedge clk);
        end
        wr(tpt_pkg::OFF_COMMON, 16'h0000, 2'b10);
        rdchk(ad(2, tpt_pkg::REG_CNT), 16'h0005);
        // ch1 phase mode, reverse quadrature: four steps down
        wr(ad(1, tpt_pkg::REG_CTRL), 16'h0001, 2'b01);
        wr(ad(1, tpt_pkg::REG_CNT), 16'h0000, 2'b11);
        wr(tpt_pkg::OFF_COMMON, 16'h0200, 2'b10);
        for (int k = 0; k < 4; k++) begin
            phaseBIn <= {1'b0, k < 2};
            phaseAIn <= {1'b0, k == 1 || k == 2};
            repeat (4) @(posedge clk);
        end
        wr(tpt_pkg::OFF_COMMON, 16'h0000, 2'b10);
        rdchk(ad(1, tpt_pkg::REG_CNT), 16'hfffc);
        // lockstep clear: ch0 clears on A match at 0010, ch1 follows; 42 steps, period 17
        wr(ad(1, tpt_pkg::REG_CTRL), 16'h0300, 2'b11);
        wr(ad(0, tpt_pkg::REG_CTRL), 16'h0100, 2'b10);
        wr(ad(0, tpt_pkg::REG_GENERAL_REG_A), 16'h0010, 2'b11);
        wr(tpt_pkg::OFF_COMMON, 16'h0003, 2'b01);
        wr(ad(0, tpt_pkg::REG_CNT), 16'h0000, 2'b11);
        wr(tpt_pkg::OFF_COMMON, 16'h0300, 2'b10);
        repeat (40) @(posedge clk);
        wr(tpt_pkg::OFF_COMMON, 16'h0000, 2'b10);
        rdchk(ad(0, tpt_pkg::REG_CNT), 16'h0008);
        rdchk(ad(1, tpt_pkg::REG_CNT), 16'h0008);
        end_of_test();
    end
endmodule
`default_nettype wire
